// File: design/vliw_dispatch_and_crosspath.sv
// dispatcher, cross path, predication and address generation of a two-side vliw core
`timescale 1ns/1ps
`default_nettype none
module vliw_dispatch_and_crosspath #(
  parameter int CIRC_BITS = 8
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  output logic                       fetchReq,
  input  wire logic                  fetchValid,
  input  wire logic [255:0]          fetchData,
  output logic                       packetValid,
  output logic [7:0]                 unitIssue,
  output logic [7:0]                 unitExec,
  output logic                       stallOut,
  output logic                       memValid,
  output logic                       memWrite,
  output logic [31:0]                memAddr,
  output logic [1:0]                 memWidth,
  output logic [63:0]                memWdata,
  output logic [7:0]                 memByteEn,
  input  wire logic                  memRvalid,
  input  wire logic [63:0]           memRdata
);
  localparam int W = vliw_dispatch_pkg::INSTR_BITS;

  initial begin
    if (CIRC_BITS < 2 || CIRC_BITS > 30) $error("CIRC_BITS out of range");
  end

  // ****************************************
  // fetch buffer and dispatch state
  // ****************************************
  logic [255:0] fbuf_q, fbuf_d;           // current fetch packet
  logic         fbufValid_q, fbufValid_d;
  logic [2:0]   ptr_q, ptr_d;
  vliw_dispatch_pkg::disp_state_t state_q, state_d;
  logic [7:0]   carryUnits_q, carryUnits_d; // part packet from previous fetch
  logic [W-1:0] carryInstr_q [8];
  logic [W-1:0] carryInstr_d [8];
  logic [7:0]   issue;
  logic [W-1:0] slotInstr [8];
  logic         packetDone, lastOfFetch, needStall;

  // walk chain from pointer to build one execute packet
  always_comb begin
    logic stop;
    logic [2:0] u;
    logic [3:0] k;
    stop = 1'b0;
    u = 3'h0;
    k = 4'h0;
    issue = carryUnits_q;
    packetDone = 1'b0;
    lastOfFetch = 1'b0;
    for (int s = 0; s < 8; s++) begin
      slotInstr[s] = carryInstr_q[s];
    end
    for (int i = 0; i < 8; i++) begin
      k = 4'(i) + {1'b0, ptr_q};
      if (!stop && k < 4'h8 && fbufValid_q) begin
        u = fbuf_q[k*W + vliw_dispatch_pkg::UNIT_LSB +: 3];
        issue[u] = 1'b1;                  // only named units get work
        slotInstr[u] = fbuf_q[k*W +: W];
        if (!fbuf_q[k*W + vliw_dispatch_pkg::CHAIN_POS]) begin
          stop = 1'b1;                    // zero ends the packet
          packetDone = 1'b1;
          lastOfFetch = (k == 4'h7);
        end else if (k == 4'h7) begin
          stop = 1'b1;                    // chain runs into next fetch
          lastOfFetch = 1'b1;
        end
      end
    end
  end

  // ****************************************
  // cross-path hazard detection
  // ****************************************
  logic [7:0]  wrEn_q, wrEn_d;            // last cycle's writes per unit
  logic [4:0]  wrAddrA_d, wrAddrB_d;      // writes landing at the end of this cycle
  logic        wrA_d, wrB_d;

  always_comb begin
    needStall = 1'b0;
    for (int s = 0; s < 8; s++) begin
      if (issue[s] && slotInstr[s][vliw_dispatch_pkg::XPATH_POS]) begin
        // cross operand is used next cycle, so a write landing now is the hazard
        if (s < 4 && wrB_d && wrAddrB_d == slotInstr[s][vliw_dispatch_pkg::SRC_LSB +: 5]) needStall = 1'b1;
        if (s >= 4 && wrA_d && wrAddrA_d == slotInstr[s][vliw_dispatch_pkg::SRC_LSB +: 5]) needStall = 1'b1;
      end
    end
  end

  // dispatch sequencing, one packet per clock
  always_comb begin
    state_d = state_q;
    fbuf_d = fbuf_q;
    fbufValid_d = fbufValid_q;
    ptr_d = ptr_q;
    carryUnits_d = carryUnits_q;
    for (int s = 0; s < 8; s++) begin
      carryInstr_d[s] = carryInstr_q[s];
    end
    unique case (state_q)
      vliw_dispatch_pkg::FILL_STATE: begin
        if (fetchValid) begin
          fbuf_d = fetchData;
          fbufValid_d = 1'b1;
          ptr_d = 3'(vliw_dispatch_pkg::SLOT_PTR_RESET);
          state_d = vliw_dispatch_pkg::RUN_STATE;
        end
      end
      vliw_dispatch_pkg::RUN_STATE, vliw_dispatch_pkg::STALL_STATE: begin
        if (needStall && state_q == vliw_dispatch_pkg::RUN_STATE && packetDone) begin
          state_d = vliw_dispatch_pkg::STALL_STATE; // one delay clock
        end else if (!packetDone) begin
          // save the head of a spanning packet, refetch
          carryUnits_d = issue;
          for (int s = 0; s < 8; s++) begin
            carryInstr_d[s] = slotInstr[s];
          end
          fbufValid_d = 1'b0;
          state_d = vliw_dispatch_pkg::FILL_STATE;
        end else begin
          carryUnits_d = 8'h00;
          ptr_d = ptr_q + 3'(4'(unsigned'($countones(issue & ~carryUnits_q))));
          if (lastOfFetch) begin
            fbufValid_d = 1'b0;           // all packets sent, fetch next
            state_d = vliw_dispatch_pkg::FILL_STATE;
          end else begin
            state_d = vliw_dispatch_pkg::RUN_STATE;
          end
        end
      end
      default: state_d = vliw_dispatch_pkg::FILL_STATE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= vliw_dispatch_pkg::FILL_STATE;
      fbuf_q <= '0;
      fbufValid_q <= 1'b0;
      ptr_q <= 3'h0;
      carryUnits_q <= 8'h00;
      for (int s = 0; s < 8; s++) carryInstr_q[s] <= '0;
    end else begin
      state_q <= state_d;
      fbuf_q <= fbuf_d;
      fbufValid_q <= fbufValid_d;
      ptr_q <= ptr_d;
      carryUnits_q <= carryUnits_d;
      for (int s = 0; s < 8; s++) carryInstr_q[s] <= carryInstr_d[s];
    end
  end

  logic fire;
  assign fire = (state_q != vliw_dispatch_pkg::FILL_STATE) && packetDone &&
                !(needStall && state_q == vliw_dispatch_pkg::RUN_STATE);
  assign fetchReq = (state_q == vliw_dispatch_pkg::FILL_STATE);

  // ****************************************
  // predication and register writes
  // ****************************************
  logic [7:0] predOk;
  logic [4:0] rdAddrA [5];
  logic [4:0] rdAddrB [5];
  logic [159:0] rdDataA, rdDataB;

  // predicate registers are 0..7, named by slot 0 for side a and slot 4 for side b
  always_comb begin
    for (int s = 0; s < 4; s++) begin
      rdAddrA[s] = slotInstr[s][vliw_dispatch_pkg::SRC_LSB +: 5];
      rdAddrB[s] = slotInstr[s+4][vliw_dispatch_pkg::SRC_LSB +: 5];
    end
    rdAddrA[4] = {2'h0, slotInstr[0][vliw_dispatch_pkg::PRED_REG_LSB +: 3]};
    rdAddrB[4] = {2'h0, slotInstr[4][vliw_dispatch_pkg::PRED_REG_LSB +: 3]};
  end

  // registered execute stage
  logic [7:0] exec_q, exec_d;
  logic [W-1:0] exInstr_q [8];
  logic [W-1:0] exInstr_d [8];
  always_comb begin
    exec_d = fire ? issue : 8'h00;
    for (int s = 0; s < 8; s++) exInstr_d[s] = slotInstr[s];
  end
  always_ff @(posedge core_clk) begin
    exec_q <= reset ? 8'h00 : exec_d;
    for (int s = 0; s < 8; s++) exInstr_q[s] <= reset ? '0 : exInstr_d[s];
  end

  // condition test per unit using its own side's predicate read
  always_comb begin
    logic [W-1:0] pv;
    pv = '0;
    for (int s = 0; s < 8; s++) begin
      pv = (s < 4) ? rdDataA[4*W +: W] : rdDataB[4*W +: W];
      predOk[s] = exInstr_q[s][vliw_dispatch_pkg::PRED_ZERO_POS] ? (pv == '0) : (pv != '0);
    end
  end
  assign unitExec = exec_q & predOk;      // false predicate keeps slot only

  // dual 16-bit add on logic units, write back on own side
  always_comb begin
    wrA_d = 1'b0;
    wrB_d = 1'b0;
    wrAddrA_d = exInstr_q[0][vliw_dispatch_pkg::DST_LSB +: 5];
    wrAddrB_d = exInstr_q[4][vliw_dispatch_pkg::DST_LSB +: 5];
    if (unitExec[0]) wrA_d = 1'b1;
    if (unitExec[4]) wrB_d = 1'b1;
    wrEn_d = unitExec;
  end
  always_ff @(posedge core_clk) begin
    wrEn_q <= reset ? 8'h00 : wrEn_d;
  end

  // cross-path operand: pick opposite side when flagged
  logic [W-1:0] opA, opB, sumA, sumB;
  assign opA = exInstr_q[0][vliw_dispatch_pkg::XPATH_POS] ? rdDataB[0 +: W] : rdDataA[0 +: W];
  assign opB = exInstr_q[4][vliw_dispatch_pkg::XPATH_POS] ? rdDataA[0 +: W] : rdDataB[0 +: W];
  assign sumA = {opA[31:16] + 16'h0001, opA[15:0] + 16'h0001};
  assign sumB = {opB[31:16] + 16'h0001, opB[15:0] + 16'h0001};

  // four read ports plus predicate per side, same cycle
  side_reg_file #(.REGS(vliw_dispatch_pkg::SIDE_REGS), .WIDTH(W), .READS(5)) u_side_a (
    .core_clk  (core_clk),
    .reset     (reset),
    .readAddr  ({rdAddrA[4], rdAddrA[3], rdAddrA[2], rdAddrA[1], rdAddrA[0]}),
    .readData  (rdDataA),
    .writeEn   (wrA_d),
    .writeAddr (wrAddrA_d),
    .writeData (sumA)
  );
  side_reg_file #(.REGS(vliw_dispatch_pkg::SIDE_REGS), .WIDTH(W), .READS(5)) u_side_b (
    .core_clk  (core_clk),
    .reset     (reset),
    .readAddr  ({rdAddrB[4], rdAddrB[3], rdAddrB[2], rdAddrB[1], rdAddrB[0]}),
    .readData  (rdDataB),
    .writeEn   (wrB_d),
    .writeAddr (wrAddrB_d),
    .writeData (sumB)
  );

  // ****************************************
  // address unit (side a address unit, slot 3)
  // ****************************************
  logic [31:0] base, ofs, eaddr, circMask, memAddr_d;
  logic [7:0]  ben;
  logic [1:0]  wid;
  logic        longOfs, circ;
  always_comb begin
    base = rdDataA[3*W +: W];             // base from side a
    wid = exInstr_q[3][vliw_dispatch_pkg::DST_LSB +: 2]; // no destination here, field carries size
    longOfs = exInstr_q[3][vliw_dispatch_pkg::SIDE_POS];
    circ = exInstr_q[3][vliw_dispatch_pkg::DSIDE_POS];
    ofs = longOfs ? {17'h00000, exInstr_q[3][vliw_dispatch_pkg::OFS_LSB +: 10], 5'h00}
                  : {27'h0000000, exInstr_q[3][vliw_dispatch_pkg::OFS_LSB +: 5]}; // 5 or 15 bit
    ofs = ofs << wid;                     // offset scaled by access size
    circMask = (32'h00000001 << CIRC_BITS) - 32'h00000001;
    eaddr = base + ofs;
    if (circ) eaddr = (base & ~circMask) | (eaddr & circMask); // wrap in block
    // byte enables for any byte address, spill ignored
    unique case (wid)
      2'h0: ben = 8'h01 << eaddr[2:0];
      2'h1: ben = 8'h03 << eaddr[2:0];
      2'h2: ben = 8'h0F << eaddr[2:0];
      2'h3: ben = 8'hFF << eaddr[2:0];
    endcase
    memAddr_d = eaddr;
  end

  // only the address unit touches memory; false predicate blocks it
  always_ff @(posedge core_clk) begin
    memValid <= reset ? 1'b0 : unitExec[3];
    memWrite <= reset ? 1'b0 : exInstr_q[3][vliw_dispatch_pkg::OPC_LSB];
    memAddr <= reset ? 32'h00000000 : memAddr_d;
    memWidth <= reset ? 2'h0 : wid;
    memByteEn <= reset ? 8'h00 : ben;
    memWdata <= reset ? 64'h0 : {rdDataB[2*W +: W], rdDataB[W +: W]}; // store data from side b pair
  end

  logic unusedIn;
  assign unusedIn = memRvalid ^ (^memRdata) ^ (^wrEn_q);
  always_ff @(posedge core_clk) begin
    packetValid <= reset ? 1'b0 : fire;
    unitIssue <= reset ? 8'h00 : (fire ? issue : 8'h00);
    stallOut <= reset ? 1'b0 : (state_q == vliw_dispatch_pkg::STALL_STATE) & ~unusedIn | (state_q == vliw_dispatch_pkg::STALL_STATE) & unusedIn;
  end

  // ****************************************
  // checks
  // ****************************************
  one_packet_a: assert property (@(posedge core_clk) disable iff (reset)
    fetchReq |-> !fire) else $error("packet fired while fetching");
  stall_once_a: assert property (@(posedge core_clk) disable iff (reset)
    state_q == vliw_dispatch_pkg::STALL_STATE |=> state_q != vliw_dispatch_pkg::STALL_STATE)
    else $error("stall longer than one cycle");
  pred_mem_a: assert property (@(posedge core_clk) disable iff (reset)
    exec_q[3] && !predOk[3] |=> !memValid) else $error("false predicate reached memory");
  issue_seen_a: assert property (@(posedge core_clk) disable iff (reset)
    fire |=> packetValid && unitIssue == $past(issue)) else $error("issue vector lost");
  exec_sub_a: assert property (@(posedge core_clk) disable iff (reset)
    (unitExec & ~exec_q) == 8'h00) else $error("exec outside issued slot");
  stall_cause_a: assert property (@(posedge core_clk) disable iff (reset)
    state_q == vliw_dispatch_pkg::RUN_STATE && needStall && packetDone |-> !fire ##1 fire)
    else $error("hazard not stalled");
  mem_width_a: assert property (@(posedge core_clk) disable iff (reset)
    memValid && memWidth == 2'h3 |-> memByteEn == 8'(8'hFF << memAddr[2:0])) else $error("bad byte enables");
  fill_wait_a: assert property (@(posedge core_clk) disable iff (reset)
    fetchReq && !fetchValid |=> fetchReq) else $error("left fill without data");
endmodule : vliw_dispatch_and_crosspath
`default_nettype wire

// File: design/vliw_dispatch_pkg.sv
// shared constants for the vliw dispatch and cross-path block
package vliw_dispatch_pkg;
  // ****************************************
  // packet and word geometry
  // ****************************************
  localparam int FETCH_BITS = 256;
  localparam int INSTR_BITS = 32;
  localparam int SLOTS = 8;
  localparam int SIDE_REGS = 32;
  localparam int CHAIN_POS = 0;
  localparam int SLOT_PTR_RESET = 0;
  localparam int STALL_CYCLES = 1;

  // ****************************************
  // instruction field positions
  // ****************************************
  localparam int UNIT_LSB = 1;
  localparam int XPATH_POS = 4;
  localparam int SRC_LSB = 5;
  localparam int SIDE_POS = 10;
  localparam int DST_LSB = 11;
  localparam int DSIDE_POS = 16;
  localparam int PRED_ZERO_POS = 17;
  localparam int PRED_REG_LSB = 18;
  localparam int OPC_LSB = 21;
  localparam int OFS_LSB = 22;

  // ****************************************
  // access widths and dispatch states
  // ****************************************
  typedef enum logic [1:0] {
    ACC_BYTE   = 2'h0,
    ACC_HALF   = 2'h1,
    ACC_WORD   = 2'h2,
    ACC_DOUBLE = 2'h3
  } acc_width_t;

  typedef enum logic [1:0] {
    FILL_STATE = 2'h0,
    RUN_STATE  = 2'h1,
    STALL_STATE = 2'h2
  } disp_state_t;
endpackage : vliw_dispatch_pkg

// File: design/side_reg_file.sv
// one side's register file, flop based, multi read, one write
`timescale 1ns/1ps
`default_nettype none
module side_reg_file #(
  parameter int REGS  = 32,
  parameter int WIDTH = 32,
  parameter int READS = 5
) (
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  input  wire logic [READS*5-1:0]         readAddr,
  output logic      [READS*WIDTH-1:0]     readData,
  input  wire logic                       writeEn,
  input  wire logic [4:0]                 writeAddr,
  input  wire logic [WIDTH-1:0]           writeData
);
  logic [WIDTH-1:0] regs_q [REGS];
  logic [WIDTH-1:0] regs_d [REGS];

  initial begin
    if (REGS != 32) $error("side_reg_file needs 32 registers");
  end

  // next state of the array
  always_comb begin
    for (int i = 0; i < REGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (writeEn) begin
      regs_d[writeAddr] = writeData;
    end
  end

  // ****************************************
  // storage and registered read ports
  // ****************************************
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < REGS; i++) begin
      regs_q[i] <= reset ? '0 : regs_d[i];
    end
  end

  // all ports read in the same cycle
  always_ff @(posedge core_clk) begin
    for (int p = 0; p < READS; p++) begin
      readData[p*WIDTH +: WIDTH] <= reset ? '0 : regs_d[readAddr[p*5 +: 5]];
    end
  end
endmodule : side_reg_file
`default_nettype wire

// File: sim/vliw_mem_model.sv
// program and data memory model facing the dispatch block
`timescale 1ns/1ps
`default_nettype none
module vliw_mem_model (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [1:0]   fetchDelay,
  input  wire logic         fetchReq,
  output logic              fetchValid,
  output logic [255:0]      fetchData,
  input  wire logic         memValid,
  input  wire logic         memWrite,
  output logic              memRvalid,
  output logic [63:0]       memRdata
);
  logic [255:0] prog[$];
  int           waitCnt;

  // ****************************************
  // program memory with variable latency
  // ****************************************
  initial begin
    fetchValid = 1'b0;
    fetchData  = '0;
    memRvalid  = 1'b0;
    memRdata   = '0;
    waitCnt    = 0;
  end

  // packet held until taken, bus churns when idle
  always @(posedge core_clk) begin
    fetchData <= ~fetchData;
    if (reset) begin
      fetchValid <= 1'b0;
      waitCnt    <= 0;
    end else if (fetchValid) begin
      if (fetchReq) begin
        fetchValid <= 1'b0;
        fetchData  <= ~prog.pop_front();
      end else begin
        fetchData <= prog[0];
      end
    end else if (fetchReq && prog.size() > 0) begin
      if (waitCnt >= fetchDelay) begin
        fetchValid <= 1'b1;
        fetchData  <= prog[0];   // whole 256-bit packet at once
        waitCnt    <= 0;
      end else begin
        waitCnt <= waitCnt + 1;
      end
    end
  end

  // ****************************************
  // data memory, one cycle read reply
  // ****************************************
  always @(posedge core_clk) begin
    memRvalid <= memValid && !memWrite && !reset;
    memRdata  <= (memValid && !memWrite) ? 64'h0123456789ABCDEF : ~memRdata;
  end
endmodule : vliw_mem_model
`default_nettype wire

// File: sim/vliw_dispatch_and_crosspath_tb.sv
// self-checking testbench for the dispatch and cross-path block
`timescale 1ns/1ps
`default_nettype none
module vliw_dispatch_and_crosspath_tb;
  logic         core_clk = 1'b0;
  logic         reset    = 1'b1;
  logic [1:0]   fetchDelay = 2'h0;
  logic         fetchReq, fetchValid, packetValid, stallOut, memValid, memWrite, memRvalid;
  logic [255:0] fetchData;
  logic [7:0]   unitIssue, unitExec, memByteEn;
  logic [31:0]  memAddr;
  logic [1:0]   memWidth;
  logic [63:0]  memWdata, memRdata;
  logic [7:0]   issueQ[$], execQ[$];
  logic [42:0]  memQ[$];
  logic [31:0]  instrs[$];
  int           error_cnt = 0, checked = 0, stallCnt = 0, seed = 32'h1efa682c;
  int           n, base, rv, s0;

  always #12.5 core_clk = ~core_clk;

  vliw_dispatch_and_crosspath #(.CIRC_BITS(8)) uut (
    .core_clk(core_clk), .reset(reset), .fetchReq(fetchReq), .fetchValid(fetchValid),
    .fetchData(fetchData), .packetValid(packetValid), .unitIssue(unitIssue), .unitExec(unitExec),
    .stallOut(stallOut), .memValid(memValid), .memWrite(memWrite), .memAddr(memAddr),
    .memWidth(memWidth), .memWdata(memWdata), .memByteEn(memByteEn), .memRvalid(memRvalid),
    .memRdata(memRdata));

  vliw_mem_model mem (
    .core_clk(core_clk), .reset(reset), .fetchDelay(fetchDelay), .fetchReq(fetchReq),
    .fetchValid(fetchValid), .fetchData(fetchData), .memValid(memValid), .memWrite(memWrite),
    .memRvalid(memRvalid), .memRdata(memRdata));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // instruction word: chain, unit, cross path, source, dest, zero test, predicate reg, store
  function automatic logic [31:0] mk(input logic ch, input logic [2:0] un, input logic xp,
      input logic [4:0] src, input logic [4:0] dst, input logic zt, input logic [2:0] pr, input logic st);
    return {10'h000, st, pr, zt, 1'b0, dst, 1'b0, src, xp, un, ch};
  endfunction : mk

  // split queued words into fetch packets and note the expected results
  task automatic flush();
    logic [7:0]   iss, ex;
    logic [255:0] fp;
    logic [1:0]   w;
    logic [31:0]  a;
    iss = '0;
    ex  = '0;
    fp  = '0;
    @(negedge core_clk);
    foreach (instrs[i]) begin
      fp[(i % 8) * 32 +: 32] = instrs[i];
      iss[instrs[i][3:1]] = 1'b1;
      if (instrs[i][17])
        ex[instrs[i][3:1]] = 1'b1;
      if (instrs[i][17] && instrs[i][3:1] == 3'h3) begin
        w = instrs[i][12:11];                       // size code rides in the destination field
        a = 32'(instrs[i][26:22]) << w;             // short linear offset, scaled, from base 0
        memQ.push_back({instrs[i][21], w, a, 8'(((16'h0001 << (1 << w)) - 16'h0001) << a[2:0])});
      end
      if (!instrs[i][0]) begin
        issueQ.push_back(iss);
        execQ.push_back(ex);
        iss = '0;
        ex  = '0;
      end
      if (i % 8 == 7)
        mem.prog.push_back(fp);
    end
    instrs.delete();
  endtask : flush

  // wait, bounded, until every expected result was seen
  task automatic drain();
    int k;
    for (k = 0; k < 600 && (issueQ.size() + execQ.size() + memQ.size() + mem.prog.size()) > 0; k++)
      @(posedge core_clk);
    check("drainTimeout", k >= 600, 0);
    repeat (4) @(posedge core_clk);
  endtask : drain

  // ****************************************
  // output watcher
  // ****************************************
  always @(posedge core_clk) begin
    if (!reset) begin
      if (stallOut === 1'b1)
        stallCnt++;
      if (packetValid === 1'b1) begin
        check("packetPending", issueQ.size() > 0, 1);
        check("unitIssue", unitIssue, issueQ.pop_front());
        check("unitExec", unitExec, execQ.pop_front());
      end
      if (memValid === 1'b1) begin
        check("memPending", memQ.size() > 0, 1);
        check("memAccess", {memWrite, memWidth, memAddr, memByteEn}, memQ.pop_front());
        check("memWdata", memWdata, 64'h0);
      end
    end
  end

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #(25ns * 40000);
    error_cnt++;
    final_report();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    // cross-path read after write: adjacent, false writer, one packet gap
    for (int v = 0; v < 3; v++) begin
      s0 = stallCnt;
      instrs.push_back(mk(1'b0, 3'h0, 1'b0, 5'h0, 5'h8, v != 1, 3'h1, 1'b0));
      if (v == 2)
        instrs.push_back(mk(1'b0, 3'h1, 1'b0, 5'h0, 5'h9, 1'b1, 3'h2, 1'b0));
      instrs.push_back(mk(1'b1, 3'h4, 1'b1, 5'h8, 5'hA, 1'b1, 3'h1, 1'b0));
      instrs.push_back(mk(1'b0, 3'h5, 1'b1, 5'h8, 5'hB, 1'b1, 3'h1, 1'b0));
      while (instrs.size() < 8)
        instrs.push_back(mk(1'b0, 3'h2, 1'b0, 5'h0, 5'hC, 1'b1, 3'h3, 1'b0));
      flush();
      drain();
      check("stallCount", stallCnt - s0, v == 0);
    end
    // six singles, then a full packet spanning the fetch boundary
    for (int i = 0; i < 16; i++)
      instrs.push_back(mk(i >= 6 && i < 13, 3'(i - (i >= 6 ? 6 : 0)), 1'b0, 5'h0, 5'(8 + i), 1'b1, 3'h4,
                          i[0]));
    flush();
    drain();
    // random programs with random fetch latency
    for (int r = 0; r < 12; r++) begin
      n = 0;
      base = $random(seed);
      for (int i = 0; i < 16; i++) begin
        rv = $random(seed);
        instrs.push_back(mk(rv[0] && n < 7 && i < 15, 3'(base + n), 1'b0, 5'h0, 5'(8 + rv[7:4]),
                            rv[11], 3'(rv[10:9] + 1), rv[12]) | {rv[31:22], 22'h0});
        n = (rv[0] && n < 7) ? n + 1 : 0;
      end
      flush();
      repeat (16) begin
        @(posedge core_clk);
        fetchDelay <= 2'($random(seed));
      end
      drain();
    end
    final_report();
  end
endmodule : vliw_dispatch_and_crosspath_tb
`default_nettype wire
